// ### inc/dtc_pkg.sv
/*
 dtc_pkg: register map, field positions, reset values and mode codes
 for the dual timer/event counter. Assumes a 10 MHz system clock.
*/
package dtc_pkg;
	// printed offsets are register indices; byte address is four times
	localparam logic [7:0] DTC_IDX_C0_VALUE = 8'h0D;
	localparam logic [7:0] DTC_IDX_C0_CTRL = 8'h0E;
	localparam logic [7:0] DTC_IDX_C1_VALUE = 8'h10;
	localparam logic [7:0] DTC_IDX_C1_CTRL = 8'h11;
	localparam logic [7:0] DTC_IDX_FLAGS = 8'h0B;
	localparam int DTC_ADDR_W = 10;
	localparam int DTC_FLAG0_BIT = 5;
	localparam int DTC_FLAG1_BIT = 6;
	localparam int DTC_PSC_LSB = 0;
	localparam int DTC_EDGE_BIT = 3;
	localparam int DTC_RUN_BIT = 4;
	localparam int DTC_MODE_LSB = 6;
	localparam logic [7:0] DTC_C0_CTRL_RST = 8'h08;
	localparam logic [7:0] DTC_C1_CTRL_RST = 8'h08;
	localparam logic [7:0] DTC_C0_CTRL_MASK = 8'hDF;
	localparam logic [7:0] DTC_C1_CTRL_MASK = 8'hD8;
	localparam logic [7:0] DTC_FLAGS_MASK = 8'h60;
	localparam logic [7:0] DTC_VALUE_RST = 8'h00;
	localparam logic [1:0] DTC_INSTR_DIV_LAST = 2'h3;
	localparam logic [1:0] DTC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DTC_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		DTC_MODE_UNUSED = 2'h0,
		DTC_MODE_EVENT = 2'h1,
		DTC_MODE_TIMER = 2'h2,
		DTC_MODE_PULSE = 2'h3
	} dtc_mode_t;
endpackage : dtc_pkg

// ### core/dtc_counter.sv
/*
 dtc_counter: one 8-bit up counter with preload, event / timer /
 pulse-width modes. Assumes synchronised pin level and a one-cycle
 internal tick from the parent; all on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module dtc_counter
	import dtc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// configuration
	input wire logic [1:0] mode,
	input wire logic edge_sel,
	input wire logic run,
	input wire logic tick,
	input wire logic hold,
	// synchronised pin level
	input wire logic pin_level,
	// preload write
	input wire logic load_we,
	input wire logic [7:0] load_data,
	// results
	output logic [7:0] count,
	output logic overflow,
	output logic run_clear
);
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] pre;
		logic pin_prev;
		logic busy;
		logic done;
		logic ovf;
		logic rclr;
	} dtc_cnt_state_t;
	dtc_cnt_state_t s_q, s_d;
	logic rise, fall, start_edge, stop_edge, inc;

	always_comb
	begin
		s_d = s_q;
		s_d.ovf = 1'b0;
		s_d.rclr = 1'b0;
		s_d.pin_prev = pin_level;
		rise = pin_level & ~s_q.pin_prev;
		fall = ~pin_level & s_q.pin_prev;
		start_edge = edge_sel ? rise : fall;
		stop_edge = edge_sel ? fall : rise;
		inc = 1'b0;
		unique case (dtc_mode_t'(mode))
			DTC_MODE_EVENT: inc = run & (edge_sel ? fall : rise);
			DTC_MODE_TIMER: inc = run & tick;
			DTC_MODE_PULSE:
			begin
				if (!run)
				begin
					s_d.busy = 1'b0;
					s_d.done = 1'b0;
				end
				else if (s_q.busy && stop_edge)
				begin
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
					s_d.rclr = 1'b1;
				end
				else if (!s_q.busy && !s_q.done && start_edge)
					s_d.busy = 1'b1;
				inc = s_q.busy & tick & ~stop_edge;
			end
			DTC_MODE_UNUSED: inc = 1'b0;
		endcase
		// reads freeze the count for that cycle
		if (hold)
			inc = 1'b0;
		if (inc)
		begin
			if (s_q.cnt == 8'hFF)
			begin
				s_d.cnt = s_q.pre;
				s_d.ovf = 1'b1;
			end
			else
				s_d.cnt = s_q.cnt + 8'h01;
		end
		if (load_we)
		begin
			s_d.pre = load_data;
			if (!run)
				s_d.cnt = load_data;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			s_q <= '0;
			s_q.cnt <= DTC_VALUE_RST;
			s_q.pre <= DTC_VALUE_RST;
		end
		else
			s_q <= s_d;
	end

	assign count = s_q.cnt;
	assign overflow = s_q.ovf;
	assign run_clear = s_q.rclr;
endmodule : dtc_counter
`default_nettype wire

// ### core/dtc_top.sv
/*
 dtc_top: two 8-bit timer/event counters behind an AXI4-Lite slave,
 with prescaler, instruction-clock divider and buzzer output.
 Assumes ref_clk at 10 MHz, synchronous active-high reset, and
 asynchronous event pins that are synchronised here.
*/
// Notes on behaviour
// - two 8-bit up counters; clocked by pin or internal divided clock
// - counter 0 overflows make buzzer frequency f/(2*(256-preload))
// - counter 0 at 0DH, control 0EH; counter 1 at 10H, control 11H
// - data write stores preload; data read returns live count
// - event mode 01 counts transitions of the external pin
// - timer mode: counter 0 on prescaled clock, counter 1 on clock/4
// - pulse mode 11 counts internal clock while pin holds chosen level
// - event/timer: reach FFH, reload preload and set flag bit 5/6
// - pulse mode: start on chosen edge, stop on return, clear run bit
// - after measurement hold result until run bit set again
// - prescale code 000 divides by 2 up to 111 dividing by 256
// - event mode edge select 1 counts falling, 0 counts rising
// - pulse mode edge select 1 rise-to-fall, 0 fall-to-rise
// - mode bits 7:6: 01 event, 10 timer, 11 pulse, 00 unused
// - run bit 4 enables; only software clears it outside pulse mode
// - data write while stopped loads counter too; running only preload
// - counter clock blocked during a read of its data address
`timescale 1ns/1ns
`default_nettype none
module dtc_top
	import dtc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// axi4-lite write address
	input wire logic [DTC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [DTC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// external event pins
	input wire logic event0_pin,
	input wire logic event1_pin,
	// buzzer
	output logic buzzer_freq_output,
	output logic buzzer_freq_output_n
);
	typedef struct packed {
		logic [1:0] sync0;
		logic [1:0] sync1;
		logic [7:0] psc;
		logic [1:0] idiv;
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic flag0;
		logic flag1;
		logic buzz;
		logic aw_got;
		logic [DTC_ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dtc_top_state_t;
	dtc_top_state_t s_q, s_d;

	logic [7:0] count0, count1;
	logic ovf0, ovf1, rclr0, rclr1;
	logic tick0, tick1, wr_fire, rd_fire, hold0, hold1;
	logic ld0, ld1;
	logic [7:0] widx, ridx;

	// word index from byte address; misaligned bits make it unmapped
	function automatic logic [7:0] reg_index(
		input logic [DTC_ADDR_W-1:0] addr
	);
		reg_index = (addr[1:0] != 2'h0) ? 8'hFF : addr[9:2];
	endfunction : reg_index

	function automatic logic mapped(input logic [7:0] idx);
		mapped = (idx == DTC_IDX_C0_VALUE) || (idx == DTC_IDX_C0_CTRL) ||
			(idx == DTC_IDX_C1_VALUE) || (idx == DTC_IDX_C1_CTRL) ||
			(idx == DTC_IDX_FLAGS);
	endfunction : mapped

	// divide-by-2^(code+1) tick: counter bits all ones below the tap
	function automatic logic psc_tick(
		input logic [7:0] psc,
		input logic [2:0] code
	);
		logic [7:0] m;
		m = 8'hFF >> (3'h7 - code);
		psc_tick = ((psc & m) == m);
	endfunction : psc_tick

	assign s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
	assign s_axi_wready = ~s_q.w_got & ~s_q.bvalid;
	assign s_axi_arready = ~s_q.rvalid;
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	assign wr_fire = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
	assign widx = reg_index(s_q.aw_addr);
	assign ridx = reg_index(s_axi_araddr);
	assign hold0 = rd_fire & (ridx == DTC_IDX_C0_VALUE);
	assign hold1 = rd_fire & (ridx == DTC_IDX_C1_VALUE);
	assign ld0 = wr_fire & s_q.w_lane0 & (widx == DTC_IDX_C0_VALUE);
	assign ld1 = wr_fire & s_q.w_lane0 & (widx == DTC_IDX_C1_VALUE);
	assign tick0 = psc_tick(s_q.psc, s_q.ctrl0[DTC_PSC_LSB +: 3]);
	assign tick1 = (s_q.idiv == DTC_INSTR_DIV_LAST);

	dtc_counter u_cnt0 (
		.ref_clk(ref_clk),
		.reset(reset),
		.mode(s_q.ctrl0[DTC_MODE_LSB +: 2]),
		.edge_sel(s_q.ctrl0[DTC_EDGE_BIT]),
		.run(s_q.ctrl0[DTC_RUN_BIT]),
		.tick(tick0),
		.hold(hold0),
		.pin_level(s_q.sync0[1]),
		.load_we(ld0),
		.load_data(s_q.w_data),
		.count(count0),
		.overflow(ovf0),
		.run_clear(rclr0)
	);

	dtc_counter u_cnt1 (
		.ref_clk(ref_clk),
		.reset(reset),
		.mode(s_q.ctrl1[DTC_MODE_LSB +: 2]),
		.edge_sel(s_q.ctrl1[DTC_EDGE_BIT]),
		.run(s_q.ctrl1[DTC_RUN_BIT]),
		.tick(tick1),
		.hold(hold1),
		.pin_level(s_q.sync1[1]),
		.load_we(ld1),
		.load_data(s_q.w_data),
		.count(count1),
		.overflow(ovf1),
		.run_clear(rclr1)
	);

	always_comb
	begin
		s_d = s_q;
		s_d.sync0 = {s_q.sync0[0], event0_pin};
		s_d.sync1 = {s_q.sync1[0], event1_pin};
		s_d.psc = s_q.psc + 8'h01;
		s_d.idiv = s_q.idiv + 2'h1;
		if (ovf0)
			s_d.buzz = ~s_q.buzz;
		// write channel capture
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_axi_wdata[7:0];
			s_d.w_lane0 = s_axi_wstrb[0];
		end
		if (wr_fire)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = mapped(widx) ? DTC_RESP_OKAY : DTC_RESP_SLVERR;
			if (s_q.w_lane0)
			begin
				unique case (widx)
					DTC_IDX_C0_CTRL:
						s_d.ctrl0 = s_q.w_data & DTC_C0_CTRL_MASK;
					DTC_IDX_C1_CTRL:
						s_d.ctrl1 = s_q.w_data & DTC_C1_CTRL_MASK;
					DTC_IDX_FLAGS:
					begin
						s_d.flag0 = s_q.w_data[DTC_FLAG0_BIT];
						s_d.flag1 = s_q.w_data[DTC_FLAG1_BIT];
					end
					default: ;
				endcase
			end
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		// hardware events win over software writes
		if (rclr0)
			s_d.ctrl0[DTC_RUN_BIT] = 1'b0;
		if (rclr1)
			s_d.ctrl1[DTC_RUN_BIT] = 1'b0;
		if (ovf0)
			s_d.flag0 = 1'b1;
		if (ovf1)
			s_d.flag1 = 1'b1;
		// read channel
		if (rd_fire)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp = mapped(ridx) ? DTC_RESP_OKAY : DTC_RESP_SLVERR;
			s_d.rdata = 32'h0000_0000;
			unique case (ridx)
				DTC_IDX_C0_VALUE: s_d.rdata[7:0] = count0;
				DTC_IDX_C0_CTRL: s_d.rdata[7:0] = s_q.ctrl0;
				DTC_IDX_C1_VALUE: s_d.rdata[7:0] = count1;
				DTC_IDX_C1_CTRL: s_d.rdata[7:0] = s_q.ctrl1;
				DTC_IDX_FLAGS:
				begin
					s_d.rdata[DTC_FLAG0_BIT] = s_q.flag0;
					s_d.rdata[DTC_FLAG1_BIT] = s_q.flag1;
				end
				default: ;
			endcase
		end
		else if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			s_q <= '0;
			s_q.ctrl0 <= DTC_C0_CTRL_RST;
			s_q.ctrl1 <= DTC_C1_CTRL_RST;
		end
		else
			s_q <= s_d;
	end

	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign buzzer_freq_output = s_q.buzz;
	assign buzzer_freq_output_n = ~s_q.buzz;
endmodule : dtc_top
`default_nettype wire

// ### verif/dtc_props.sv
/*
 dtc_props: port checker for dtc_top.
 Assumes a bind from the bench top, one clock and a sync reset.
*/
`timescale 1ns/1ns
`default_nettype none
module dtc_props
	import dtc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// bus
	input wire logic [DTC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// buzzer
	input wire logic buzzer_freq_output,
	input wire logic buzzer_freq_output_n
);
	logic [DTC_ADDR_W-1:0] ar_q;
	logic [7:0] idx;
	logic mapped;
	assign idx = ar_q[9:2];
	assign mapped = ar_q[1:0] == 2'h0 && idx inside {DTC_IDX_C0_VALUE,
		DTC_IDX_C0_CTRL, DTC_IDX_C1_VALUE, DTC_IDX_C1_CTRL, DTC_IDX_FLAGS};
	always_ff @(posedge ref_clk)
	begin
		if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	buzz_pair_a: assert property (
		buzzer_freq_output_n != buzzer_freq_output) else $error("buzzer pair");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
	read_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read dropped");
	write_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	ar_gate_a: assert property (
		s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
	ctrl1_zero_a: assert property (
		s_axi_rvalid && idx == DTC_IDX_C1_CTRL |-> (s_axi_rdata & ~32'hD8) == 0)
		else $error("ctrl1 unused bits set");
	unmapped_rd_a: assert property (
		s_axi_rvalid && !mapped |-> s_axi_rresp == DTC_RESP_SLVERR
		&& s_axi_rdata == 0) else $error("unmapped read");
	mapped_rd_a: assert property (
		s_axi_rvalid && mapped |-> s_axi_rresp == DTC_RESP_OKAY
		&& s_axi_rdata[31:8] == 0) else $error("mapped read");
	cover property (s_axi_rvalid && !mapped);
	cover property ($rose(buzzer_freq_output));
	cover property (s_axi_bvalid && s_axi_bresp == DTC_RESP_SLVERR);
endmodule : dtc_props
`default_nettype wire

// ### verif/dtc_pin_model.sv
/*
 dtc_pin_model: drives n pulses of w cycles high, w low on an event pin.
 Assumes go is a one-cycle request on ref_clk; pin idles low.
*/
`timescale 1ns/1ns
`default_nettype none
module dtc_pin_model
(
	// clock and request
	input wire logic ref_clk,
	input wire logic go,
	input wire logic [7:0] n,
	input wire logic [7:0] w,
	// pin
	output logic pin,
	output logic busy
);
	// one process owns pin and busy, so each has a single driver
	initial
	begin
		pin = 1'b0;
		busy = 1'b0;
		forever
		begin
			@(posedge ref_clk);
			if (go)
			begin
				busy <= 1'b1;
				repeat (n)
				begin
					pin <= 1'b1;
					repeat (w) @(posedge ref_clk);
					pin <= 1'b0;
					repeat (w) @(posedge ref_clk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule : dtc_pin_model
`default_nettype wire

// ### verif/dtc_tb_top.sv
/*
 dtc_tb_top: self-checking bench for dtc_top over AXI4-Lite.
 Assumes the package map; pin models drive both event inputs.
*/
`timescale 1ns/1ns
`default_nettype none
module dtc_tb_top
	import dtc_pkg::*;
;
	localparam logic [9:0] AV0 = {DTC_IDX_C0_VALUE, 2'b00};
	localparam logic [9:0] AC0 = {DTC_IDX_C0_CTRL, 2'b00};
	localparam logic [9:0] AV1 = {DTC_IDX_C1_VALUE, 2'b00};
	localparam logic [9:0] AC1 = {DTC_IDX_C1_CTRL, 2'b00};
	localparam logic [9:0] AF = {DTC_IDX_FLAGS, 2'b00};
	logic ref_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, event0_pin, event1_pin;
	logic buzzer_freq_output, buzzer_freq_output_n, go0, go1, busy0, busy1;
	logic [9:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] n1, w1, rd;
	int fail_count, tests_run;
	dtc_top dtc_top_inst (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event0_pin, .event1_pin,
		.buzzer_freq_output, .buzzer_freq_output_n);
	dtc_pin_model pin0 (.ref_clk, .go(go0), .n(8'h01), .w(8'h28),
		.pin(event0_pin), .busy(busy0));
	dtc_pin_model pin1 (.ref_clk, .go(go1), .n(n1), .w(w1),
		.pin(event1_pin), .busy(busy1));
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task stop_test;
		$display("errors %0d of %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task tmo;
		fail_count++;
		$display("[ERR] %0t wait ran out", $time);
		stop_test;
	endtask : tmo
	// sample handshakes at the falling edge: settled until the next rise
	task wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
		int k;
		logic aw, w, b;
		logic [1:0] r;
		b = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 200 && !b; k++)
		begin
			@(negedge ref_clk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge ref_clk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (!b)
			tmo();
		chk(r, er);
	endtask : wr
	task rdr(input logic [9:0] a, input logic [1:0] er);
		int k;
		logic ar, b;
		logic [1:0] r;
		b = 1'b0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 200 && !b; k++)
		begin
			@(negedge ref_clk);
			ar = s_axi_arready;
			b = s_axi_rvalid;
			rd = s_axi_rdata[7:0];
			r = s_axi_rresp;
			@(posedge ref_clk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (!b)
			tmo();
		chk(r, er);
	endtask : rdr
	task fire(input logic s);
		int k;
		@(posedge ref_clk);
		go0 <= !s;
		go1 <= s;
		@(posedge ref_clk);
		go0 <= 1'b0;
		go1 <= 1'b0;
		@(posedge ref_clk);
		for (k = 0; k < 999 && (busy0 || busy1); k++)
			@(posedge ref_clk);
		if (busy0 || busy1)
			tmo();
		// pin synchroniser and edge detect settle
		repeat (6) @(posedge ref_clk);
	endtask : fire
	initial
	begin : main
		int i, n, c, t;
		logic [7:0] p, m;
		logic f, bz;
		{reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'hF - 4'h7;
		{s_axi_arvalid, s_axi_rready, go0, go1} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
		s_axi_wstrb = 4'hF;
		n1 = 8'h01;
		w1 = 8'h04;
		i = $urandom(97);
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		rdr(AC0, DTC_RESP_OKAY);
		chk(rd, DTC_C0_CTRL_RST);
		rdr(AC1, DTC_RESP_OKAY);
		chk(rd, DTC_C1_CTRL_RST);
		rdr(10'h03C, DTC_RESP_SLVERR);
		wr(10'h03C, 8'h55, DTC_RESP_SLVERR);
		p = 8'($urandom);
		wr(AC1, p & 8'hEF, DTC_RESP_OKAY);
		rdr(AC1, DTC_RESP_OKAY);
		chk(rd, p & 8'hC8);
		wr(AC0, p & 8'hEF, DTC_RESP_OKAY);
		rdr(AC0, DTC_RESP_OKAY);
		chk(rd, p & 8'hCF);
		for (i = 0; i < 4; i++)
		begin
			p = 8'($urandom_range(255, 250));
			n = $urandom_range(6, 1);
			wr(AC1, 8'h00, DTC_RESP_OKAY);
			wr(AV1, p, DTC_RESP_OKAY);
			rdr(AV1, DTC_RESP_OKAY);
			chk(rd, p);
			wr(AF, 8'h00, DTC_RESP_OKAY);
			wr(AC1, 8'h50 | {4'h0, i[0], 3'h0}, DTC_RESP_OKAY);
			c = p;
			f = 1'b0;
			repeat (n)
			begin
				f = f | (c == 255);
				c = (c == 255) ? p : c + 1;
			end
			n1 <= 8'(n);
			fire(1'b1);
			rdr(AV1, DTC_RESP_OKAY);
			chk(rd, c[7:0]);
			rdr(AF, DTC_RESP_OKAY);
			chk(rd, {1'b0, f, 6'h0});
		end
		wr(AV1, 8'h11, DTC_RESP_OKAY);
		rdr(AV1, DTC_RESP_OKAY);
		chk(rd, c[7:0]);
		// counter 1 timer: 404 running cycles of the clock/4 tick
		wr(AC1, 8'h00, DTC_RESP_OKAY);
		wr(AV1, 8'h00, DTC_RESP_OKAY);
		wr(AC1, 8'h90, DTC_RESP_OKAY);
		repeat (400) @(posedge ref_clk);
		wr(AC1, 8'h10, DTC_RESP_OKAY);
		rdr(AV1, DTC_RESP_OKAY);
		m = rd;
		chk(m >= 8'h64 && m <= 8'h66, 1);
		repeat (40) @(posedge ref_clk);
		rdr(AV1, DTC_RESP_OKAY);
		chk(rd, m);
		// counter 1 pulse width, low level: fall starts, rise stops
		wr(AC1, 8'h00, DTC_RESP_OKAY);
		wr(AV1, 8'h00, DTC_RESP_OKAY);
		wr(AC1, 8'hD0, DTC_RESP_OKAY);
		n1 <= 8'h02;
		w1 <= 8'h28;
		fire(1'b1);
		rdr(AV1, DTC_RESP_OKAY);
		chk(rd >= 8'h09 && rd <= 8'h0B, 1);
		rdr(AC1, DTC_RESP_OKAY);
		chk(rd, 8'hC0);
		wr(AC0, 8'h08, DTC_RESP_OKAY);
		wr(AV0, 8'h00, DTC_RESP_OKAY);
		wr(AC0, 8'hD8, DTC_RESP_OKAY);
		fire(1'b0);
		rdr(AV0, DTC_RESP_OKAY);
		m = rd;
		chk(m >= 8'h13 && m <= 8'h15, 1);
		rdr(AC0, DTC_RESP_OKAY);
		chk(rd, 8'hC8);
		fire(1'b0);
		rdr(AV0, DTC_RESP_OKAY);
		chk(rd, m);
		wr(AV0, 8'hF0, DTC_RESP_OKAY);
		wr(AF, 8'h00, DTC_RESP_OKAY);
		wr(AC0, 8'h90, DTC_RESP_OKAY);
		t = 0;
		bz = buzzer_freq_output;
		repeat (640)
		begin
			@(negedge ref_clk);
			t = t + (buzzer_freq_output != bz);
			bz = buzzer_freq_output;
		end
		chk(t >= 19 && t <= 21, 1);
		rdr(AF, DTC_RESP_OKAY);
		chk(rd[5], 1'b1);
		stop_test;
	end
endmodule : dtc_tb_top
bind dtc_top dtc_props dtc_props_inst (.ref_clk, .reset, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .buzzer_freq_output, .buzzer_freq_output_n);
`default_nettype wire
